// ### design/swdc_core.sv
// swdc_core.sv: configuration and timing core of a supervisory watchdog
// assumes host commands are one-cycle strobes on clk and module_on is asynchronous
//
// Behaviour
// - after reset, restart or enable, withhold all resets until hold-off elapses
// - supervision timer starts only after hold-off fully expires
// - writing hold-off or off-recovery timeout disables the watchdog
// - nonzero off-recovery: watch on/off; restart module after timeout when off
// - zero off-recovery timeout, the default, disables observation and restart
// - load-defaults takes only argument one, restores defaults, disables watchdog
// - restored timeouts apply at next enable; other settings apply at once
// - restored defaults are written to nonvolatile storage
// - slave address programmable 1 to 127, default 0x6A, kept across power
// - new slave address applies at once, enable state unchanged
// - direction setting is 10 bits, default zero, kept nonvolatile
// - direction bit one drives shifter to output, zero to input
// - bits 0..9 steer lines 6,7,8,11,12,13,22,23,21,20 in order
`timescale 1ns/100ps
`include "swdc_params.svh"
`default_nettype none
module swdc_core
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host commands
   input wire logic cmd_enable,
   input wire logic cmd_disable,
   input wire logic wr_holdoff,
   input wire logic wr_offrec,
   input wire logic wr_addr,
   input wire logic wr_dir,
   input wire logic load_factory_settings,
   input wire logic [31:0] cmd_arg,
   output logic cmd_error,
   // nonvolatile store, restored image and write request
   input wire logic nv_valid,
   input wire swdc_pkg::swdc_ms_t nv_holdoff,
   input wire swdc_pkg::swdc_ms_t nv_offrec,
   input wire logic [6:0] nv_addr,
   input wire logic [9:0] nv_dir,
   output logic nv_write,
   output swdc_pkg::swdc_ms_t nv_wr_holdoff,
   output swdc_pkg::swdc_ms_t nv_wr_offrec,
   output logic [6:0] nv_wr_addr,
   output logic [9:0] nv_wr_dir,
   // supervised module
   input wire logic module_on,
   input wire logic module_restarted,
   input wire logic supv_expired,
   output logic module_reset,
   // status and configuration views
   output logic wd_enabled,
   output logic holdoff_active,
   output logic supv_run,
   output logic [6:0] slave_addr,
   // level shifter directions, index is the module line number
   output logic dir_line6,
   output logic dir_line7,
   output logic dir_line8,
   output logic dir_line11,
   output logic dir_line12,
   output logic dir_line13,
   output logic dir_line22,
   output logic dir_line23,
   output logic dir_line21,
   output logic dir_line20
);
   import swdc_pkg::*;

   swdc_ms_t cfg_holdoff, cfg_offrec, act_holdoff, act_offrec;
   logic [9:0] dir_cfg;
   logic on_s1, on_s2, rs_s1, rs_s2, rs_prev;
   logic nv_seen;
   swdc_state_t state, next_state;
   logic hold_done, rec_done, pulse_done;

   function automatic logic addr_ok(input logic [31:0] a);
      addr_ok = (a[31:7] == 25'h0000000) && (a[6:0] >= `SWDC_ADDR_MIN);
   endfunction : addr_ok

   function automatic logic dir_ok(input logic [31:0] a);
      dir_ok = (a[31:10] == 22'h000000);
   endfunction : dir_ok

   wire logic load_ok = load_factory_settings && (cmd_arg == `SWDC_LOAD_ARG);
   wire logic addr_good = wr_addr && addr_ok(cmd_arg);
   wire logic dir_good = wr_dir && dir_ok(cmd_arg);
   wire logic cfg_disable = wr_holdoff || wr_offrec || load_ok || cmd_disable;
   wire logic restarted = rs_s2 && !rs_prev;
   wire logic enable_go = cmd_enable && !cfg_disable;
   wire logic obs_on = (act_offrec != 32'h00000000);
   wire logic module_off = obs_on && !on_s2;

   swdc_tick_if tick_bus();
   swdc_ms_tick u_tick (.clk(clk), .rst(rst), .tick(tick_bus));

   // hold-off reloads on enable and module restart
   wire logic hold_load = enable_go || (restarted && wd_enabled) ||
                          (state == SWDC_RESTART && pulse_done);
   swdc_ms_timer u_hold (.clk(clk), .rst(rst), .tick(tick_bus), .load(hold_load),
                         .value(enable_go ? cfg_holdoff : act_holdoff), .done(hold_done));

   // off-recovery counts only while module is off
   wire logic rec_load = (state != SWDC_RUN) || !module_off;
   swdc_ms_timer u_rec (.clk(clk), .rst(rst), .tick(tick_bus), .load(rec_load),
                        .value(act_offrec), .done(rec_done));

   wire logic pulse_load = (state != SWDC_RESTART);
   swdc_ms_timer u_pulse (.clk(clk), .rst(rst), .tick(tick_bus), .load(pulse_load),
                          .value(`SWDC_RST_PULSE_MS), .done(pulse_done));

   // synchronisers for the module's asynchronous indications
   always_ff @(posedge clk)
   begin
      on_s1 <= module_on;
      on_s2 <= on_s1;
      rs_s1 <= module_restarted;
      rs_s2 <= rs_s1;
      rs_prev <= rs_s2;
   end

   // timeouts latch to active copies only at enable
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         act_holdoff <= `SWDC_DEF_HOLDOFF_MS;
         act_offrec <= `SWDC_DEF_OFFREC_MS;
      end
      else if (enable_go)
      begin
         act_holdoff <= cfg_holdoff;
         act_offrec <= cfg_offrec;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg_holdoff <= `SWDC_DEF_HOLDOFF_MS;
         cfg_offrec <= `SWDC_DEF_OFFREC_MS;
         slave_addr <= `SWDC_DEF_ADDR;
         dir_cfg <= `SWDC_DEF_DIR;
         nv_seen <= 1'b0;
      end
      else if (load_ok)
      begin
         cfg_holdoff <= `SWDC_DEF_HOLDOFF_MS;
         cfg_offrec <= `SWDC_DEF_OFFREC_MS;
         slave_addr <= `SWDC_DEF_ADDR;
         dir_cfg <= `SWDC_DEF_DIR;
      end
      else if (nv_valid && !nv_seen)
      begin
         cfg_holdoff <= nv_holdoff;
         cfg_offrec <= nv_offrec;
         slave_addr <= (nv_addr == 7'h00) ? `SWDC_DEF_ADDR : nv_addr;
         dir_cfg <= nv_dir;
         nv_seen <= 1'b1;
      end
      else
      begin
         if (wr_holdoff)
            cfg_holdoff <= cmd_arg;
         if (wr_offrec)
            cfg_offrec <= cmd_arg;
         if (addr_good)
            slave_addr <= cmd_arg[6:0];
         if (dir_good)
            dir_cfg <= cmd_arg[9:0];
      end
   end

   // persist every accepted change, defaults included
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         nv_write <= 1'b0;
         cmd_error <= 1'b0;
      end
      else
      begin
         nv_write <= load_ok || wr_holdoff || wr_offrec || addr_good || dir_good;
         cmd_error <= (load_factory_settings && !load_ok) || (wr_addr && !addr_good) ||
                      (wr_dir && !dir_good);
      end
   end
   assign nv_wr_holdoff = cfg_holdoff;
   assign nv_wr_offrec = cfg_offrec;
   assign nv_wr_addr = slave_addr;
   assign nv_wr_dir = dir_cfg;

   always_ff @(posedge clk)
   begin
      if (rst || cfg_disable)
         wd_enabled <= 1'b0;
      else if (cmd_enable)
         wd_enabled <= 1'b1;
   end

   always_comb
   begin
      next_state = state;
      case (state)
         SWDC_IDLE:
            if (enable_go)
               next_state = SWDC_HOLD;
         SWDC_HOLD:
            if (hold_done && !hold_load)
               next_state = SWDC_RUN;
         SWDC_RUN:
            if (restarted)
               next_state = SWDC_HOLD;
            else if ((module_off && rec_done) || supv_expired)
               next_state = SWDC_RESTART;
         SWDC_RESTART:
            if (pulse_done)
               next_state = SWDC_HOLD;
         default:
            next_state = SWDC_IDLE;
      endcase
      if (cfg_disable)
         next_state = SWDC_IDLE;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state <= SWDC_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         module_reset <= 1'b0;
      else
         module_reset <= (next_state == SWDC_RESTART);
   end

   assign holdoff_active = (state == SWDC_HOLD);
   assign supv_run = (state == SWDC_RUN);

   // one is output, zero is input
   assign dir_line6 = dir_cfg[0];
   assign dir_line7 = dir_cfg[1];
   assign dir_line8 = dir_cfg[2];
   assign dir_line11 = dir_cfg[3];
   assign dir_line12 = dir_cfg[4];
   assign dir_line13 = dir_cfg[5];
   assign dir_line22 = dir_cfg[6];
   assign dir_line23 = dir_cfg[7];
   assign dir_line21 = dir_cfg[8];
   assign dir_line20 = dir_cfg[9];

   // assertions
   // no reset in hold-off
   a_hold_no_reset: assert property (@(posedge clk) disable iff (rst)
      holdoff_active |=> !module_reset)
      else $error("reset during hold-off");
   a_run_after_hold: assert property (@(posedge clk) disable iff (rst)
      (supv_run && !$past(supv_run)) |-> $past(hold_done))
      else $error("supervision before hold-off end");
   a_write_disables: assert property (@(posedge clk) disable iff (rst)
      (wr_holdoff || wr_offrec) |=> !wd_enabled && state == SWDC_IDLE)
      else $error("timeout write left watchdog on");
   a_off_restart: assert property (@(posedge clk) disable iff (rst)
      (supv_run && module_off && rec_done && !restarted && !cfg_disable) |=> module_reset)
      else $error("module left off past timeout");
   a_zero_no_restart: assert property (@(posedge clk) disable iff (rst)
      (act_offrec == 32'h00000000 && !supv_expired && state == SWDC_RUN) |=> !module_reset)
      else $error("restart with zero timeout");
   sequence s_load_cmd;
      load_factory_settings && cmd_arg == `SWDC_LOAD_ARG;
   endsequence
   a_load_defaults: assert property (@(posedge clk) disable iff (rst)
      s_load_cmd |=> (cfg_holdoff == `SWDC_DEF_HOLDOFF_MS && slave_addr == `SWDC_DEF_ADDR
                     && dir_cfg == `SWDC_DEF_DIR && !wd_enabled))
      else $error("defaults not restored");
   a_load_persist: assert property (@(posedge clk) disable iff (rst)
      s_load_cmd |=> nv_write ##0 (nv_wr_dir == `SWDC_DEF_DIR))
      else $error("defaults not persisted");
   a_addr_range: assert property (@(posedge clk) disable iff (rst)
      (wr_addr && cmd_arg == 32'h00000000 && (nv_seen || !nv_valid)) |=>
      $stable(slave_addr) && cmd_error)
      else $error("address zero accepted");
   a_addr_keeps_en: assert property (@(posedge clk) disable iff (rst)
      (wr_addr && !cfg_disable && !cmd_enable) |=> $stable(wd_enabled))
      else $error("address write changed enable");
   a_defer_timeout: assert property (@(posedge clk) disable iff (rst)
      (wr_holdoff && !cmd_enable) |=> $stable(act_holdoff))
      else $error("hold-off applied before enable");
endmodule : swdc_core
`default_nettype wire

// ### design/swdc_ms_tick.sv
// swdc_ms_tick.sv: one-cycle pulse every millisecond
// assumes clk at the rate in swdc_params.svh
`timescale 1ns/100ps
`include "swdc_params.svh"
`default_nettype none
module swdc_ms_tick
(
   input wire logic clk,
   input wire logic rst,
   swdc_tick_if.src tick
);
   logic [14:0] cnt;
   wire logic wrap = (cnt == 15'(`SWDC_CYC_PER_MS - 1));
   assign tick.ms_tick = wrap;
   always_ff @(posedge clk)
   begin
      if (rst || wrap)
         cnt <= 15'h0000;
      else
         cnt <= cnt + 15'h0001;
   end
endmodule : swdc_ms_tick
`default_nettype wire

// ### design/swdc_ms_timer.sv
// swdc_ms_timer.sv: 32-bit millisecond down-counter with load and done flag
// assumes a millisecond tick from swdc_ms_tick
`timescale 1ns/100ps
`default_nettype none
module swdc_ms_timer
(
   input wire logic clk,
   input wire logic rst,
   swdc_tick_if.dst tick,
   input wire logic load,
   input wire swdc_pkg::swdc_ms_t value,
   output logic done
);
   import swdc_pkg::*;
   swdc_ms_t cnt;
   assign done = (cnt == 32'h00000000);
   always_ff @(posedge clk)
   begin
      if (rst)
         cnt <= 32'h00000000;
      else if (load)
         cnt <= value;
      else if (tick.ms_tick && !done)
         cnt <= cnt - 32'h00000001;
   end
endmodule : swdc_ms_timer
`default_nettype wire

// ### design/swdc_params.svh
// swdc_params.svh: constants of the supervisory watchdog configuration core
// assumes a 20 MHz clock and millisecond timing
`ifndef SWDC_PARAMS_SVH
`define SWDC_PARAMS_SVH
`define SWDC_CLK_HZ 20000000
`define SWDC_MS_PER_S 1000
`define SWDC_CYC_PER_MS (`SWDC_CLK_HZ / `SWDC_MS_PER_S)
`define SWDC_DEF_HOLDOFF_MS 32'h001B7740
`define SWDC_DEF_OFFREC_MS 32'h00000000
`define SWDC_DEF_ADDR 7'h6A
`define SWDC_DEF_DIR 10'h000
`define SWDC_LOAD_ARG 32'h00000001
`define SWDC_ADDR_MIN 7'h01
`define SWDC_RST_PULSE_MS 32'h00000064
`endif

// ### design/swdc_pkg.sv
// swdc_pkg.sv: types of the supervisory watchdog configuration core
// assumes swdc_params.svh defines the numbers
package swdc_pkg;
   typedef logic [31:0] swdc_ms_t;
   typedef enum logic [1:0] {SWDC_IDLE, SWDC_HOLD, SWDC_RUN, SWDC_RESTART} swdc_state_t;
endpackage : swdc_pkg

// ### design/swdc_tick_if.sv
// swdc_tick_if.sv: millisecond tick carrier between core and its counters
// assumes a single clock domain
`timescale 1ns/100ps
`default_nettype none
interface swdc_tick_if;
   logic ms_tick;
   modport src (output ms_tick);
   modport dst (input ms_tick);
endinterface : swdc_tick_if
`default_nettype wire

// ### verification/swdc_module_model.sv
// swdc_module_model.sv: behavioural supervised module at the watchdog's far side
// assumes module_reset is a level from the core on the same clock
`timescale 1ns/100ps
`default_nettype none
module swdc_module_model
#(
   parameter int BOOT_CYC = 40
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // power switch from bench, reset from core
   input wire logic power_off,
   input wire logic module_reset,
   // module status
   output logic module_on,
   output logic module_restarted
);
   int boot;
   // off while reset or unpowered, then boots and flags the restart
   always_ff @(posedge clk)
   begin
      if (rst || module_reset || power_off)
      begin
         module_on <= 1'b0;
         module_restarted <= 1'b0;
         boot <= BOOT_CYC;
      end
      else
      begin
         if (boot > 0)
            boot <= boot - 1;
         module_restarted <= (boot == 1);
         if (boot == 1)
            module_on <= 1'b1;
      end
   end
endmodule : swdc_module_model
`default_nettype wire

// ### verification/tb_supervisory_watchdog_config.sv
// tb_supervisory_watchdog_config.sv: self-checking bench of the watchdog core
// assumes swdc_core and swdc_module_model are compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb_supervisory_watchdog_config;
   localparam int k_en = 0;
   localparam int k_dis = 1;
   localparam int k_hold = 2;
   localparam int k_off = 3;
   localparam int k_addr = 4;
   localparam int k_dir = 5;
   localparam int k_load = 6;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [6:0] stb = 7'h00;
   logic [31:0] arg = 32'h0;
   logic supv_expired = 1'b0;
   logic power_off = 1'b0;
   logic nv_valid = 1'b0;
   logic [6:0] nv_addr = 7'h00;
   logic [9:0] nv_dir = 10'h000;
   logic [9:0] pin_out = 10'h000;
   logic cmd_error, nv_write, module_on, module_restarted, module_reset;
   logic wd_enabled, holdoff_active, supv_run;
   logic [6:0] slave_addr, nv_wr_addr;
   logic [9:0] nv_wr_dir;
   wire logic [9:0] dirs;
   swdc_pkg::swdc_ms_t nv_wr_holdoff, nv_wr_offrec;
   logic [1:0] f;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;
   int n;

   swdc_core dut_u
   (
      .clk(clk), .rst(rst),
      .cmd_enable(stb[0]), .cmd_disable(stb[1]), .wr_holdoff(stb[2]), .wr_offrec(stb[3]),
      .wr_addr(stb[4]), .wr_dir(stb[5]), .load_factory_settings(stb[6]), .cmd_arg(arg),
      .cmd_error(cmd_error), .nv_valid(nv_valid), .nv_holdoff(32'h0), .nv_offrec(32'h0),
      .nv_addr(nv_addr), .nv_dir(nv_dir), .nv_write(nv_write), .nv_wr_holdoff(nv_wr_holdoff),
      .nv_wr_offrec(nv_wr_offrec), .nv_wr_addr(nv_wr_addr), .nv_wr_dir(nv_wr_dir),
      .module_on(module_on), .module_restarted(module_restarted),
      .supv_expired(supv_expired), .module_reset(module_reset), .wd_enabled(wd_enabled),
      .holdoff_active(holdoff_active), .supv_run(supv_run), .slave_addr(slave_addr),
      .dir_line6(dirs[0]), .dir_line7(dirs[1]), .dir_line8(dirs[2]), .dir_line11(dirs[3]),
      .dir_line12(dirs[4]), .dir_line13(dirs[5]), .dir_line22(dirs[6]),
      .dir_line23(dirs[7]), .dir_line21(dirs[8]), .dir_line20(dirs[9])
   );

   swdc_module_model model_u
   (
      .clk(clk), .rst(rst), .power_off(power_off), .module_reset(module_reset),
      .module_on(module_on), .module_restarted(module_restarted)
   );

   initial
   begin
      forever #25 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one strobe with argument; returns {nv_write, cmd_error} seen over two cycles
   task automatic do_cmd(input int k, input logic [31:0] a, output logic [1:0] fl);
      @(posedge clk);
      stb <= 7'h01 << k;
      arg <= a;
      @(posedge clk);
      stb <= 7'h00;
      #1;
      fl = {nv_write, cmd_error};
      @(posedge clk);
      #1;
      fl = fl | {nv_write, cmd_error};
   endtask : do_cmd

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic t_defaults;
      check("addr", slave_addr, 32'h6A);
      check("dirs", dirs, 32'h000);
      check("enabled", wd_enabled, 32'h0);
   endtask : t_defaults

   task automatic t_dir;
      // shifters go to output before the module pins
      do_cmd(k_dir, 32'h2AA, f);
      pin_out = 10'h2AA;
      check("dirs", dirs, 32'h2AA);
      check("dir flags", f, 32'h2);
      check("no cross", {22'h0, pin_out & ~dirs}, 32'h0);
      do_cmd(k_dir, 32'h400, f);
      check("dir bad", f, 32'h1);
      check("dirs kept", dirs, 32'h2AA);
      do_cmd(k_dir, 32'h3FF, f);
      check("dirs max", dirs, 32'h3FF);
   endtask : t_dir

   task automatic t_addr;
      do_cmd(k_en, 32'h0, f);
      do_cmd(k_addr, 32'h0, f);
      check("addr zero", f, 32'h1);
      do_cmd(k_addr, 32'h80, f);
      check("addr big", f, 32'h1);
      do_cmd(k_addr, 32'h7F, f);
      check("addr", slave_addr, 32'h7F);
      do_cmd(k_addr, 32'h57, f);
      check("addr", slave_addr, 32'h57);
      check("enabled", wd_enabled, 32'h1);
   endtask : t_addr

   task automatic t_disable;
      do_cmd(k_hold, 32'h1B7740, f);
      check("enabled", wd_enabled, 32'h0);
      do_cmd(k_en, 32'h0, f);
      check("holdoff", {holdoff_active, supv_run}, 32'h2);
      do_cmd(k_off, 32'h0, f);
      check("enabled", wd_enabled, 32'h0);
   endtask : t_disable

   task automatic t_load;
      do_cmd(k_en, 32'h0, f);
      do_cmd(k_load, 32'h2, f);
      check("load bad", {f, wd_enabled}, 32'h3);
      // module pins back to input before the shifters
      pin_out = 10'h000;
      do_cmd(k_load, 32'h1, f);
      check("load flags", {f, wd_enabled}, 32'h4);
      check("addr", slave_addr, 32'h6A);
      check("dirs", dirs, 32'h000);
      check("no cross", {22'h0, pin_out & ~dirs}, 32'h0);
      check("nv hold", nv_wr_holdoff, 32'h1B7740);
      check("nv img", {nv_wr_offrec[9:0], nv_wr_addr, nv_wr_dir}, 32'h1A800);
      do_cmd(k_en, 32'h0, f);
      check("holdoff", holdoff_active, 32'h1);
   endtask : t_load

   task automatic t_holdoff;
      do_cmd(k_dis, 32'h0, f);
      do_cmd(k_hold, 32'h2, f);
      do_cmd(k_en, 32'h0, f);
      @(posedge clk);
      power_off <= 1'b1;
      supv_expired <= 1'b1;
      @(posedge clk);
      supv_expired <= 1'b0;
      n = 0;
      while (supv_run !== 1'b1 && n < 45000)
      begin
         @(posedge clk);
         n++;
      end
      check("run", supv_run, 32'h1);
      check("wait", n >= 19000, 32'h1);
      check("reset", module_reset, 32'h0);
      repeat (2000) @(posedge clk);
      check("no restart", module_reset, 32'h0);
   endtask : t_holdoff

   task automatic t_offrec;
      do_cmd(k_off, 32'h1, f);
      check("enabled", wd_enabled, 32'h0);
      @(posedge clk);
      power_off <= 1'b0;
      do_cmd(k_hold, 32'h1, f);
      do_cmd(k_en, 32'h0, f);
      n = 0;
      while (supv_run !== 1'b1 && n < 25000)
      begin
         @(posedge clk);
         n++;
      end
      check("run", supv_run, 32'h1);
      power_off <= 1'b1;
      n = 0;
      while (module_reset !== 1'b1 && n < 45000)
      begin
         @(posedge clk);
         n++;
      end
      check("restart", module_reset, 32'h1);
   endtask : t_offrec

   // mid-run resets restore the stored image
   task automatic t_restore;
      @(posedge clk);
      rst <= 1'b1;
      nv_valid <= 1'b1;
      nv_addr <= 7'h57;
      nv_dir <= 10'h155;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("nv addr", slave_addr, 32'h57);
      check("nv dirs", dirs, 32'h155);
      check("reset off", {wd_enabled, module_reset}, 32'h0);
      @(posedge clk);
      rst <= 1'b1;
      nv_addr <= 7'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("nv addr zero", slave_addr, 32'h6A);
   endtask : t_restore

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 100000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_defaults();
      t_dir();
      t_addr();
      t_disable();
      t_load();
      t_holdoff();
      t_offrec();
      t_restore();
      end_of_test();
   end
endmodule : tb_supervisory_watchdog_config
`default_nettype wire
